// ---- src/fst_map.svh ----
// Register offsets, reset values and timing constants of the frequency sense and torque demand block
`ifndef FST_MAP_SVH
`define FST_MAP_SVH
// ====================================================================
// Register byte offsets (word aligned)
`define FST_REG_RAMP_SEL      8'h00
`define FST_REG_ZERO_THR      8'h04
`define FST_REG_AT_WIN        8'h08
`define FST_REG_ACTIVE_CUR    8'h0c
`define FST_REG_TORQUE_DEM    8'h10
`define FST_REG_CURRENT_DEM   8'h14
`define FST_REG_CUR_LIMIT     8'h18
`define FST_REG_TORQUE_REF    8'h1c
`define FST_REG_TORQUE_OFS    8'h20
`define FST_REG_CTRL          8'h24
`define FST_REG_P_GAIN        8'h28
`define FST_REG_I_GAIN        8'h2c
`define FST_REG_THERM_TAU     8'h30
`define FST_REG_THERM_ACC     8'h34
`define FST_REG_LOAD_PCT      8'h38
`define FST_REG_STATUS        8'h3c
`define FST_REG_RATED_FREQ    8'h40
`define FST_REG_RATED_CUR     8'h44
`define FST_REG_RATED_PF      8'h48
`define FST_REG_DRIVE_CUR     8'h4c
// ====================================================================
// Field positions
`define FST_CTRL_OFS_EN       0
`define FST_CTRL_TORQUE_MODE  1
`define FST_CTRL_PROTECT      2
`define FST_STAT_ZERO         0
`define FST_STAT_AT           1
// ====================================================================
// Reset values (frequency 0.1 Hz, percent 0.1 %, current 0.01 A, pf 0.001)
`define FST_RST_ZERO_THR      16'h000a
`define FST_RST_AT_WIN        16'h000a
`define FST_MAX_THR           16'h00c8
`define FST_RST_CUR_LIMIT     16'h05dc
`define FST_RST_GAIN          8'h32
`define FST_RST_THERM_TAU     8'h59
`define FST_RST_RATED_FREQ    16'h01f4
`define FST_RST_RATED_CUR     16'h0190
`define FST_RST_RATED_PF      16'h0352
`define FST_RST_DRIVE_CUR     16'h0190
// ====================================================================
// Scaling and timing
`define FST_PCT_FULL          34'sh0000003e8
`define FST_PF_FULL           32'h000003e8
`define FST_LIMIT_NUM         32'h00000003
`define FST_LIMIT_DEN         32'h00000002
`define FST_PI_SHIFT          4
`define FST_TICK_NS           2000000
`define FST_CLK_NS            100
`endif

// ---- src/fst_pkg.sv ----
// Types shared by the frequency sense and torque demand block
package fst_pkg;
  // Ramp select terminal bits, read only
  typedef struct packed {
    logic [1:0] rev_decel;
    logic [1:0] rev_accel;
    logic [2:0] fwd_decel;
    logic [2:0] fwd_accel;
  } fst_ramp_sel_type;

  // Results of one controller iteration
  typedef struct packed {
    logic               zero_freq;
    logic               at_freq;
    logic signed [15:0] torque_demand;
    logic signed [15:0] current_demand;
    logic signed [15:0] freq_trim;
  } fst_result_type;
endpackage

// ---- src/fst_freq_sense_torque.sv ----
// Frequency sensing flags and torque to current demand conversion with Avalon-MM registers
// Overview of operation
// - Ramp select bits read only, from terminals
// - Forward accel/decel select codes are three bits
// - Reverse accel/decel select codes are two bits
// - Zero flag when abs reference within threshold
// - Zero threshold 0.0 to 20.0 Hz, default 1.0
// - At-frequency window 0.0 to 20.0 Hz, default 1.0
// - At flag inside abs reference plus/minus half window
// - Torque demand is reference plus enabled offset
// - Current demand converted, then clamped by limit
// - Below rated frequency current equals torque demand
// - Above rated frequency scale by motor/rated frequency
// - Full load current is rated current times pf
// - Positive torque motors forward, regenerates reverse
// - Active current signed, bounded by rating*pf*1.5
// - Torque mode drives frequency via PI loop
// - Controller iterates every 2 ms
`timescale 1ns/1ns
`include "fst_map.svh"
`default_nettype none

module fst_freq_sense_torque #(
  parameter int P_TICK_CYCLES = `FST_TICK_NS / `FST_CLK_NS
) (
  input  wire logic                    i_mclk,
  input  wire logic                    i_rst,
  input  wire logic [7:0]              i_avs_address,
  input  wire logic                    i_avs_read,
  input  wire logic                    i_avs_write,
  input  wire logic [31:0]             i_avs_writedata,
  input  wire logic [3:0]              i_avs_byteenable,
  output logic [31:0]                  o_avs_readdata,
  output logic                         o_avs_waitrequest,
  input  wire fst_pkg::fst_ramp_sel_type i_ramp_sel,
  input  wire logic signed [15:0]      i_post_ramp_freq,
  input  wire logic signed [15:0]      i_motor_freq,
  input  wire logic signed [15:0]      i_meas_active_cur,
  input  wire logic [15:0]             i_thermal_accum,
  output fst_pkg::fst_ramp_sel_type    o_ramp_sel,
  output fst_pkg::fst_result_type      o_result,
  output logic                         o_torque_mode,
  output logic                         o_tick
);

  // ==================================================================
  // Helpers
  // Saturate a wide signed value into 16 bits
  function automatic logic signed [15:0] sat16(input logic signed [33:0] v);
    logic signed [15:0] r;
    r = v[15:0];
    if (v > 34'sh000007fff)
      r = 16'sh7fff;
    else if (v < -34'sh000008000)
      r = -16'sh8000;
    return r;
  endfunction

  // Merge the two low byte lanes of a write into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0])
      r[7:0] = wd[7:0];
    if (be[1])
      r[15:8] = wd[15:8];
    return r;
  endfunction

  // Magnitude of a signed 16-bit value, 17 bits so -32768 is exact
  function automatic logic [16:0] mag16(input logic signed [15:0] v);
    return v[15] ? 17'(-{v[15], v}) : {1'b0, v};
  endfunction

  // ==================================================================
  // Iteration tick divider
  logic [15:0] tick_cnt;
  logic [15:0] next_tick_cnt;
  logic        tick;

  // One pulse per controller iteration
  always_comb
  begin
    tick          = (tick_cnt == 16'(P_TICK_CYCLES - 1));
    next_tick_cnt = tick ? 16'h0000 : tick_cnt + 16'h0001;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      tick_cnt <= 16'h0000;
    else
      tick_cnt <= next_tick_cnt;
  end

  // ==================================================================
  // Avalon-MM slave: one wait state on every access
  logic        ack;
  logic        next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic        wr_en;

  // Configuration registers
  logic [15:0] zero_thr, at_win, cur_limit, torque_ref, torque_ofs;
  logic [15:0] rated_freq, rated_cur, rated_pf, drive_cur;
  logic [7:0]  p_gain, i_gain, therm_tau;
  logic        ofs_en, torque_mode, protect_mode;
  logic [15:0] next_zero_thr, next_at_win, next_cur_limit, next_torque_ref, next_torque_ofs;
  logic [15:0] next_rated_freq, next_rated_cur, next_rated_pf, next_drive_cur;
  logic [7:0]  next_p_gain, next_i_gain, next_therm_tau;
  logic        next_ofs_en, next_torque_mode, next_protect_mode;

  // Results and status
  fst_pkg::fst_result_type   res, next_res;
  fst_pkg::fst_ramp_sel_type ramp_sel;
  logic signed [15:0]        active_cur, next_active_cur;
  logic signed [15:0]        load_pct, next_load_pct;
  logic signed [31:0]        integ, next_integ;

  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack;
  assign wr_en             = i_avs_write & ack;
  assign o_avs_readdata    = rdata;

  // Handshake and read mux; read data is captured during the wait state
  always_comb
  begin
    next_ack   = (i_avs_read | i_avs_write) & ~ack;
    next_rdata = rdata;
    if (i_avs_read && !ack)
    begin
      case (i_avs_address)
        `FST_REG_RAMP_SEL:    next_rdata = {22'h000000, ramp_sel};
        `FST_REG_ZERO_THR:    next_rdata = {16'h0000, zero_thr};
        `FST_REG_AT_WIN:      next_rdata = {16'h0000, at_win};
        `FST_REG_ACTIVE_CUR:  next_rdata = {{16{active_cur[15]}}, active_cur};
        `FST_REG_TORQUE_DEM:  next_rdata = {{16{res.torque_demand[15]}}, res.torque_demand};
        `FST_REG_CURRENT_DEM: next_rdata = {{16{res.current_demand[15]}}, res.current_demand};
        `FST_REG_CUR_LIMIT:   next_rdata = {16'h0000, cur_limit};
        `FST_REG_TORQUE_REF:  next_rdata = {{16{torque_ref[15]}}, torque_ref};
        `FST_REG_TORQUE_OFS:  next_rdata = {{16{torque_ofs[15]}}, torque_ofs};
        `FST_REG_CTRL:        next_rdata = {29'h00000000, protect_mode, torque_mode, ofs_en};
        `FST_REG_P_GAIN:      next_rdata = {24'h000000, p_gain};
        `FST_REG_I_GAIN:      next_rdata = {24'h000000, i_gain};
        `FST_REG_THERM_TAU:   next_rdata = {24'h000000, therm_tau};
        `FST_REG_THERM_ACC:   next_rdata = {16'h0000, i_thermal_accum};
        `FST_REG_LOAD_PCT:    next_rdata = {{16{load_pct[15]}}, load_pct};
        `FST_REG_STATUS:      next_rdata = {30'h00000000, res.at_freq, res.zero_freq};
        `FST_REG_RATED_FREQ:  next_rdata = {16'h0000, rated_freq};
        `FST_REG_RATED_CUR:   next_rdata = {16'h0000, rated_cur};
        `FST_REG_RATED_PF:    next_rdata = {16'h0000, rated_pf};
        `FST_REG_DRIVE_CUR:   next_rdata = {16'h0000, drive_cur};
        default:              next_rdata = 32'h00000000; // Unmapped reads as zero
      endcase
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      ack   <= 1'b0;
      rdata <= 32'h00000000;
    end
    else
    begin
      ack   <= next_ack;
      rdata <= next_rdata;
    end
  end

  // ==================================================================
  // Register writes; read-only and unmapped offsets ignore writes
  always_comb
  begin
    next_zero_thr     = zero_thr;
    next_at_win       = at_win;
    next_cur_limit    = cur_limit;
    next_torque_ref   = torque_ref;
    next_torque_ofs   = torque_ofs;
    next_rated_freq   = rated_freq;
    next_rated_cur    = rated_cur;
    next_rated_pf     = rated_pf;
    next_drive_cur    = drive_cur;
    next_p_gain       = p_gain;
    next_i_gain       = i_gain;
    next_therm_tau    = therm_tau;
    next_ofs_en       = ofs_en;
    next_torque_mode  = torque_mode;
    next_protect_mode = protect_mode;
    if (wr_en)
    begin
      case (i_avs_address)
        `FST_REG_ZERO_THR:   next_zero_thr   = merge16(zero_thr, i_avs_writedata, i_avs_byteenable);
        `FST_REG_AT_WIN:     next_at_win     = merge16(at_win, i_avs_writedata, i_avs_byteenable);
        `FST_REG_CUR_LIMIT:  next_cur_limit  = merge16(cur_limit, i_avs_writedata, i_avs_byteenable);
        `FST_REG_TORQUE_REF: next_torque_ref = merge16(torque_ref, i_avs_writedata, i_avs_byteenable);
        `FST_REG_TORQUE_OFS: next_torque_ofs = merge16(torque_ofs, i_avs_writedata, i_avs_byteenable);
        `FST_REG_RATED_FREQ: next_rated_freq = merge16(rated_freq, i_avs_writedata, i_avs_byteenable);
        `FST_REG_RATED_CUR:  next_rated_cur  = merge16(rated_cur, i_avs_writedata, i_avs_byteenable);
        `FST_REG_RATED_PF:   next_rated_pf   = merge16(rated_pf, i_avs_writedata, i_avs_byteenable);
        `FST_REG_DRIVE_CUR:  next_drive_cur  = merge16(drive_cur, i_avs_writedata, i_avs_byteenable);
        `FST_REG_P_GAIN:     next_p_gain     = i_avs_byteenable[0] ? i_avs_writedata[7:0] : p_gain;
        `FST_REG_I_GAIN:     next_i_gain     = i_avs_byteenable[0] ? i_avs_writedata[7:0] : i_gain;
        `FST_REG_THERM_TAU:  next_therm_tau  = i_avs_byteenable[0] ? i_avs_writedata[7:0] : therm_tau;
        `FST_REG_CTRL:
        begin
          if (i_avs_byteenable[0])
          begin
            next_ofs_en       = i_avs_writedata[`FST_CTRL_OFS_EN];
            next_torque_mode  = i_avs_writedata[`FST_CTRL_TORQUE_MODE];
            next_protect_mode = i_avs_writedata[`FST_CTRL_PROTECT];
          end
        end
        default:
        begin
        end
      endcase
    end
    // Thresholds saturate at 20.0 Hz
    if (next_zero_thr > `FST_MAX_THR)
      next_zero_thr = `FST_MAX_THR;
    if (next_at_win > `FST_MAX_THR)
      next_at_win = `FST_MAX_THR;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      zero_thr     <= `FST_RST_ZERO_THR;
      at_win       <= `FST_RST_AT_WIN;
      cur_limit    <= `FST_RST_CUR_LIMIT;
      torque_ref   <= 16'h0000;
      torque_ofs   <= 16'h0000;
      rated_freq   <= `FST_RST_RATED_FREQ;
      rated_cur    <= `FST_RST_RATED_CUR;
      rated_pf     <= `FST_RST_RATED_PF;
      drive_cur    <= `FST_RST_DRIVE_CUR;
      p_gain       <= `FST_RST_GAIN;
      i_gain       <= `FST_RST_GAIN;
      therm_tau    <= `FST_RST_THERM_TAU;
      ofs_en       <= 1'b0;
      torque_mode  <= 1'b0;
      protect_mode <= 1'b0;
    end
    else
    begin
      zero_thr     <= next_zero_thr;
      at_win       <= next_at_win;
      cur_limit    <= next_cur_limit;
      torque_ref   <= next_torque_ref;
      torque_ofs   <= next_torque_ofs;
      rated_freq   <= next_rated_freq;
      rated_cur    <= next_rated_cur;
      rated_pf     <= next_rated_pf;
      drive_cur    <= next_drive_cur;
      p_gain       <= next_p_gain;
      i_gain       <= next_i_gain;
      therm_tau    <= next_therm_tau;
      ofs_en       <= next_ofs_en;
      torque_mode  <= next_torque_mode;
      protect_mode <= next_protect_mode;
    end
  end

  // ==================================================================
  // Controller iteration; everything is computed from a consistent snapshot
  // and committed on the same tick so software never sees a mixed set
  logic [16:0]        abs_ref, abs_mf, freq_diff;
  logic signed [33:0] td_wide, cd_wide, lim, err_wide, pi_wide;
  logic signed [15:0] td, cd;
  logic [31:0]        rated_load, cur_bound;
  logic signed [33:0] meas_wide;

  always_comb
  begin
    abs_ref   = mag16(i_post_ramp_freq);
    abs_mf    = mag16(i_motor_freq);
    freq_diff = (abs_mf >= abs_ref) ? abs_mf - abs_ref : abs_ref - abs_mf;
    // Sign of torque demand carries direction and power flow; no sign folding here
    td_wide = 34'(signed'(torque_ref)) + (ofs_en ? 34'(signed'(torque_ofs)) : 34'sh000000000);
    td      = sat16(td_wide);
    // Field weakening: current rises with frequency above rated
    if (abs_mf > {1'b0, rated_freq} && rated_freq != 16'h0000)
      cd_wide = (34'(td) * 34'(signed'({1'b0, abs_mf}))) / 34'(signed'({1'b0, rated_freq}));
    else
      cd_wide = 34'(td);
    lim = 34'(signed'({1'b0, cur_limit}));
    if (cd_wide > lim)
      cd_wide = lim;
    else if (cd_wide < -lim)
      cd_wide = -lim;
    cd = sat16(cd_wide);
    // Full load current in 0.01 A from rated current and power factor
    rated_load = (32'(rated_cur) * 32'(rated_pf)) / `FST_PF_FULL;
    cur_bound  = (32'(drive_cur) * 32'(rated_pf) * `FST_LIMIT_NUM) / (`FST_PF_FULL * `FST_LIMIT_DEN);
    meas_wide  = 34'(i_meas_active_cur);
    if (meas_wide > 34'(signed'({1'b0, cur_bound})))
      meas_wide = 34'(signed'({1'b0, cur_bound}));
    else if (meas_wide < -34'(signed'({1'b0, cur_bound})))
      meas_wide = -34'(signed'({1'b0, cur_bound}));
    next_active_cur = sat16(meas_wide);
    next_load_pct   = (rated_load == 32'h00000000) ? 16'sh0000 :
                      sat16((meas_wide * `FST_PCT_FULL) / 34'(signed'({1'b0, rated_load})));
    // PI acts only in torque mode; integrator is held clear otherwise
    err_wide = 34'(cd) - 34'(load_pct);
    if (torque_mode)
    begin
      pi_wide    = 34'(integ) + err_wide * 34'(signed'({1'b0, i_gain}));
      next_integ = (pi_wide > 34'sh07fffffff) ? 32'sh7fffffff :
                   (pi_wide < -34'sh080000000) ? -32'sh80000000 : pi_wide[31:0];
      pi_wide    = (err_wide * 34'(signed'({1'b0, p_gain})) + 34'(next_integ)) >>> `FST_PI_SHIFT;
    end
    else
    begin
      next_integ = 32'sh00000000;
      pi_wide    = 34'sh000000000;
    end
    next_res.zero_freq      = (abs_ref <= {1'b0, zero_thr});
    next_res.at_freq        = ({freq_diff, 1'b0} <= {2'b00, at_win});
    next_res.torque_demand  = td;
    next_res.current_demand = cd;
    next_res.freq_trim      = sat16(pi_wide);
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      res        <= '0;
      integ      <= 32'sh00000000;
      active_cur <= 16'sh0000;
      load_pct   <= 16'sh0000;
      ramp_sel   <= '0;
    end
    else
    begin
      ramp_sel <= i_ramp_sel;
      if (tick)
      begin
        res        <= next_res;
        integ      <= next_integ;
        active_cur <= next_active_cur;
        load_pct   <= next_load_pct;
      end
    end
  end

  assign o_ramp_sel    = ramp_sel;
  assign o_result      = res;
  assign o_torque_mode = torque_mode;
  assign o_tick        = tick;

endmodule

`default_nettype wire

// ---- test/fst_freq_sense_torque_asserts.sv ----
// Port-level assertions for the frequency sense and torque demand block
`timescale 1ns/1ns
`default_nettype none

module fst_freq_sense_torque_asserts #(
  parameter int P_TICK_CYCLES = 20000
) (
  input wire logic                      i_mclk,
  input wire logic                      i_rst,
  input wire fst_pkg::fst_ramp_sel_type i_ramp_sel,
  input wire logic signed [15:0]        i_post_ramp_freq,
  input wire logic signed [15:0]        i_motor_freq,
  input wire fst_pkg::fst_ramp_sel_type o_ramp_sel,
  input wire fst_pkg::fst_result_type   o_result,
  input wire logic                      o_torque_mode,
  input wire logic                      o_tick
);
  // ==================================================================
  // Helper logic
  logic [31:0] gap;
  logic [31:0] next_gap;
  logic [16:0] ref_abs;
  logic [16:0] mot_abs;
  logic [17:0] diff2;

  // Magnitudes in 17 bits so the most negative input cannot wrap
  always_comb
  begin
    ref_abs  = i_post_ramp_freq[15] ? 17'(-17'(i_post_ramp_freq)) : 17'(i_post_ramp_freq);
    mot_abs  = i_motor_freq[15] ? 17'(-17'(i_motor_freq)) : 17'(i_motor_freq);
    diff2    = (mot_abs > ref_abs) ? {mot_abs - ref_abs, 1'b0} : {ref_abs - mot_abs, 1'b0};
    next_gap = o_tick ? 32'h0 : gap + 32'h1;
  end

  // Cycles since the last tick, restarted by reset so the first period counts too
  always_ff @(posedge i_mclk)
  begin
    gap <= i_rst ? 32'h0 : next_gap;
  end

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  // ==================================================================
  // Assertions
  chk_tick_period: assert property ((gap == P_TICK_CYCLES - 1) == o_tick)
    else $error("tick spacing wrong");
  chk_result_hold: assert property (!o_tick |=> $stable(o_result))
    else $error("result moved without tick");
  chk_zero_rest: assert property (o_tick && i_post_ramp_freq == 16'sh0 |=> o_result.zero_freq)
    else $error("zero flag low at rest");
  chk_zero_far: assert property (o_tick && ref_abs > 17'h000c8 |=> !o_result.zero_freq)
    else $error("zero flag high above any threshold");
  chk_at_match: assert property (o_tick && mot_abs == ref_abs |=> o_result.at_freq)
    else $error("at flag low on match");
  chk_at_far: assert property (o_tick && diff2 > 18'h000c8 |=> !o_result.at_freq)
    else $error("at flag high outside any window");
  chk_trim_idle: assert property (o_tick && !o_torque_mode |=> o_result.freq_trim == 16'sh0)
    else $error("trim active outside torque mode");
  chk_ramp_copy: assert property (!$past(i_rst) |-> o_ramp_sel == $past(i_ramp_sel))
    else $error("ramp select copy wrong");
endmodule

bind fst_freq_sense_torque fst_freq_sense_torque_asserts #(.P_TICK_CYCLES(P_TICK_CYCLES)) u_asserts (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_ramp_sel(i_ramp_sel), .i_post_ramp_freq(i_post_ramp_freq),
  .i_motor_freq(i_motor_freq), .o_ramp_sel(o_ramp_sel), .o_result(o_result),
  .o_torque_mode(o_torque_mode), .o_tick(o_tick));
`default_nettype wire

// ---- test/fst_partner.sv ----
// Model of the input terminals and frequency controller feeding the block
`timescale 1ns/1ns
`default_nettype none

module fst_partner (
  input  wire logic                      i_mclk,
  input  wire fst_pkg::fst_ramp_sel_type i_term,
  input  wire logic signed [15:0]        i_ref,
  input  wire logic signed [15:0]        i_mot,
  input  wire logic signed [15:0]        i_cur,
  output fst_pkg::fst_ramp_sel_type      o_ramp_sel,
  output logic signed [15:0]             o_ref,
  output logic signed [15:0]             o_mot,
  output logic signed [15:0]             o_cur,
  output logic [15:0]                    o_acc
);
  // ==================================================================
  // Terminals and measurements move only on an edge, like a sampled front end
  always_ff @(posedge i_mclk)
  begin
    o_ramp_sel <= i_term;
    o_ref      <= i_ref;
    o_mot      <= i_mot;
    o_cur      <= i_cur;
  end

  // Accumulator is not modelled; a fixed value keeps the read path fed
  assign o_acc = 16'h0123;
endmodule
`default_nettype wire

// ---- test/fst_freq_sense_torque_bench.sv ----
// Self-checking bench for the frequency sense and torque demand block
`timescale 1ns/1ns
`include "fst_map.svh"
`default_nettype none

module fst_freq_sense_torque_bench;
  localparam int P_TICK = 20;
  logic                      i_mclk = 1'b0;
  logic                      i_rst  = 1'b1;
  logic [7:0]                adr    = 8'h00;
  logic                      rd     = 1'b0;
  logic                      wr     = 1'b0;
  logic [31:0]               wdat   = 32'h0;
  logic [9:0]                term   = 10'h000;
  logic signed [15:0]        ref_f  = 16'sh0;
  logic signed [15:0]        mot_f  = 16'sh0;
  logic signed [15:0]        cur    = 16'sh0;
  logic [31:0]               rdat;
  logic [31:0]               q;
  logic                      wreq;
  logic                      tmode;
  logic                      tick;
  logic [15:0]               acc;
  logic signed [15:0]        p_ref;
  logic signed [15:0]        p_mot;
  logic signed [15:0]        p_cur;
  fst_pkg::fst_ramp_sel_type p_term;
  fst_pkg::fst_ramp_sel_type ramp_sel;
  fst_pkg::fst_result_type   res;
  int                        err_total = 0;
  int                        checks    = 0;

  // ==================================================================
  // Clock, partner and unit under test
  always #50 i_mclk = ~i_mclk;

  fst_partner u_partner (.i_mclk(i_mclk), .i_term(term), .i_ref(ref_f), .i_mot(mot_f), .i_cur(cur),
    .o_ramp_sel(p_term), .o_ref(p_ref), .o_mot(p_mot), .o_cur(p_cur), .o_acc(acc));

  fst_freq_sense_torque #(.P_TICK_CYCLES(P_TICK)) uut (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
    .i_avs_byteenable(4'hf), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_ramp_sel(p_term),
    .i_post_ramp_freq(p_ref), .i_motor_freq(p_mot), .i_meas_active_cur(p_cur), .i_thermal_accum(acc),
    .o_ramp_sel(ramp_sel), .o_result(res), .o_torque_mode(tmode), .o_tick(tick));

  // ==================================================================
  // Reporting
  task automatic final_report();
    $display("Counts: %0d checks, %0d mismatches", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // A used-up wait bound ends the run at once
  task automatic guard(input int n);
    if (n >= 200)
    begin
      err_total++;
      $display("[ERR] wait expected done seen timeout");
      final_report();
    end
  endtask

  // ==================================================================
  // Avalon master: the first edge keeps strobes of two calls apart
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_mclk);
    adr  <= a;
    wdat <= d;
    wr   <= w;
    rd   <= ~w;
    do
    begin
      @(posedge i_mclk);
      n++;
    end
    while (wreq !== 1'b0 && n < 200);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    guard(n);
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(nm, q, e);
  endtask

  // Two ticks, so partner inputs and register writes are surely sampled
  task automatic tick_wait();
    int n;
    n = 0;
    repeat (2)
    begin
      do
      begin
        @(posedge i_mclk);
        n++;
      end
      while (tick !== 1'b1 && n < 200);
    end
    @(posedge i_mclk);
    guard(n);
  endtask

  // ==================================================================
  // Test sequence
  initial
  begin
    logic [7:0]  da [11] = '{`FST_REG_ZERO_THR, `FST_REG_AT_WIN, `FST_REG_CUR_LIMIT, `FST_REG_P_GAIN,
      `FST_REG_I_GAIN, `FST_REG_THERM_TAU, `FST_REG_RATED_FREQ, `FST_REG_RATED_CUR, `FST_REG_RATED_PF,
      `FST_REG_DRIVE_CUR, `FST_REG_CTRL};
    logic [31:0] de [11] = '{32'(`FST_RST_ZERO_THR), 32'(`FST_RST_AT_WIN), 32'(`FST_RST_CUR_LIMIT),
      32'(`FST_RST_GAIN), 32'(`FST_RST_GAIN), 32'(`FST_RST_THERM_TAU), 32'(`FST_RST_RATED_FREQ),
      32'(`FST_RST_RATED_CUR), 32'(`FST_RST_RATED_PF), 32'(`FST_RST_DRIVE_CUR), 32'h0};
    logic [9:0]  rs [5] = '{10'h000, 10'h004, 10'h020, 10'h080, 10'h200};
    logic [15:0] zt [8] = '{16'h000a, 16'h000a, 16'h000a, 16'h0000, 16'h0000, 16'h000a, 16'h00c8, 16'h00c8};
    logic [15:0] zr [8] = '{16'h000a, 16'hfff6, 16'h000b, 16'h0000, 16'h0001, 16'hfe0c, 16'h012c, 16'h012c};
    logic [15:0] zm [8] = '{16'h000a, 16'hfff6, 16'h000b, 16'h0000, 16'h0001, 16'h01fa, 16'h0190, 16'h0191};
    logic [1:0]  zs [8] = '{2'h3, 2'h3, 2'h2, 2'h3, 2'h2, 2'h0, 2'h2, 2'h0};
    logic [1:0]  tc [7] = '{2'h0, 2'h1, 2'h3, 2'h1, 2'h3, 2'h0, 2'h1};
    logic [15:0] tr [7] = '{16'h012c, 16'h012c, 16'h012c, 16'h012c, 16'hfe0c, 16'hfe0c, 16'h0064};
    logic [15:0] tl [7] = '{16'h05dc, 16'h05dc, 16'h05dc, 16'h0258, 16'h0258, 16'h05dc, 16'h05dc};
    logic [15:0] tm [7] = '{16'h0190, 16'h0190, 16'h03e8, 16'h03e8, 16'hfc18, 16'h02ee, 16'h01f4};
    logic [15:0] td [7] = '{16'h012c, 16'h0190, 16'h0190, 16'h0190, 16'hfe70, 16'hfe0c, 16'h00c8};
    logic [15:0] cd [7] = '{16'h012c, 16'h0190, 16'h0320, 16'h0258, 16'hfda8, 16'hfd12, 16'h00c8};
    logic [15:0] ac [4] = '{16'h0154, 16'hff56, 16'h0258, 16'hfda8};
    logic [15:0] aa [4] = '{16'h0154, 16'hff56, 16'h01fe, 16'hfe02};
    logic [15:0] al [2] = '{16'h03e8, 16'hfe0c};
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    for (int k = 0; k < 11; k++)
      rchk("default", da[k], de[k]);
    rchk("unmapped", 8'h7c, 32'h0);
    wreg(`FST_REG_TORQUE_DEM, 32'h00001234);
    rchk("ro torque", `FST_REG_TORQUE_DEM, 32'h0);
    wreg(`FST_REG_ZERO_THR, 32'h000000fa);
    rchk("thr sat", `FST_REG_ZERO_THR, {16'h0, `FST_MAX_THR});
    wreg(`FST_REG_AT_WIN, 32'h0000ffff);
    rchk("win sat", `FST_REG_AT_WIN, {16'h0, `FST_MAX_THR});
    $display("test registers done");
    // Terminal bits read back whole and ignore writes
    for (int k = 0; k < 5; k++)
    begin
      term <= rs[k];
      wreg(`FST_REG_RAMP_SEL, 32'h000003ff);
      rchk("ramp sel", `FST_REG_RAMP_SEL, {22'h0, rs[k]});
      check("ramp out", {22'h0, ramp_sel}, {22'h0, rs[k]});
    end
    $display("test ramp select done");
    // Flag boundaries: equal to threshold, one past, both signs
    for (int k = 0; k < 8; k++)
    begin
      wreg(`FST_REG_ZERO_THR, {16'h0, zt[k]});
      wreg(`FST_REG_AT_WIN, {16'h0, zt[k]});
      ref_f <= zr[k];
      mot_f <= zm[k];
      tick_wait();
      rchk("status", `FST_REG_STATUS, {30'h0, zs[k]});
      check("zero flag", {31'h0, res.zero_freq}, {31'h0, zs[k][0]});
    end
    $display("test flags done");
    wreg(`FST_REG_TORQUE_OFS, 32'h00000064);
    for (int k = 0; k < 7; k++)
    begin
      wreg(`FST_REG_CTRL, {30'h0, tc[k]});
      wreg(`FST_REG_TORQUE_REF, {16'h0, tr[k]});
      wreg(`FST_REG_CUR_LIMIT, {16'h0, tl[k]});
      mot_f <= tm[k];
      tick_wait();
      rchk("torque dem", `FST_REG_TORQUE_DEM, {{16{td[k][15]}}, td[k]});
      rchk("current dem", `FST_REG_CURRENT_DEM, {{16{cd[k][15]}}, cd[k]});
      check("current out", {16'h0, res.current_demand}, {16'h0, cd[k]});
      check("mode", {31'h0, tmode}, {31'h0, tc[k][1]});
    end
    $display("test torque done");
    for (int k = 0; k < 4; k++)
    begin
      cur <= ac[k];
      tick_wait();
      rchk("active cur", `FST_REG_ACTIVE_CUR, {{16{aa[k][15]}}, aa[k]});
      if (k < 2) rchk("load pct", `FST_REG_LOAD_PCT, {{16{al[k][15]}}, al[k]});
    end
    $display("test current done");
    // A second reset in mid-run restores defaults
    i_rst <= 1'b1;
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    rchk("thr reset", `FST_REG_ZERO_THR, {16'h0, `FST_RST_ZERO_THR});
    $display("test reset done");
    final_report();
  end
endmodule
`default_nettype wire
